//--- shared/jtap_pkg.sv
`default_nettype none
package jtap_pkg;

  // ---------------------------------------------------------------------------
  // Controller states
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR_SCAN,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR_SCAN,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } jtap_state_e;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int IR_LEN   = 8;
  localparam int ID_LEN   = 32;
  localparam int BSC_LEN  = 87;
  localparam int BSC_OFF  = 3;
  localparam int SYNC_LEN = 2;

  // ---------------------------------------------------------------------------
  // Values
  // ---------------------------------------------------------------------------
  localparam logic [IR_LEN-1:0] IR_RESET_VAL   = 8'h03;
  localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 8'h01;
  localparam logic [IR_LEN-1:0] OPC_EXTEST     = 8'h00;
  localparam logic [IR_LEN-1:0] OPC_SAMPLE     = 8'h01;
  localparam logic [IR_LEN-1:0] OPC_IDCODE     = 8'h03;
  localparam logic [IR_LEN-1:0] OPC_BYPASS     = 8'hff;
  // Arbitrary identification value, bit 0 kept at one
  localparam logic [ID_LEN-1:0] ID_CODE        = 32'h0a5a_5001;
  localparam logic [BSC_LEN-1:0] BSC_RESET_VAL = {BSC_LEN{1'b0}};

endpackage
`default_nettype wire

//--- verilog/jtap_sync.sv
`timescale 1ns/1ps
`default_nettype none
module jtap_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // Asynchronous input and its synchronised copy
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  // ---------------------------------------------------------------------------
  // Two stage synchroniser
  // ---------------------------------------------------------------------------
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule
`default_nettype wire

//--- verilog/jtap_tap.sv
// Operation
// - Sample data and mode select on test clock rise; change data out on fall.
// - Sixteen-state controller, steered by mode select at each test clock rise.
// - Test reset pin low forces Test-Logic-Reset whatever the test clock does.
// - Five rises with mode select high reach Test-Logic-Reset from anywhere.
// - Entering Test-Logic-Reset loads instruction 0x3, selecting identification.
// - In Test-Logic-Reset the three top chain bits clear, disabling drivers.
// - Test-Logic-Reset holds on high, goes to Run-Test/Idle on low.
// - Run-Test/Idle holds on low, goes to Select-DR on high; registers keep.
// - Select-DR goes to Capture-DR on low, Select-IR on high; no action.
// - Select-IR goes to Capture-IR on low, Test-Logic-Reset on high.
// - Capture-DR loads parallel inputs; then Shift-DR on low, Exit1-DR on high.
// - Shift-DR shifts one bit toward output; holds on low, Exit1-DR on high.
// - Exit1-DR goes to Pause-DR on low, Update-DR on high.
// - Pause-DR halts shifting, keeps registers; holds on low, Exit2-DR on high.
// - Exit2-DR returns to Shift-DR on low, Update-DR on high.
// - Update-DR latches shift stage to outputs; then Idle on low, Select-DR high.
// - Capture-IR loads 00000001; then Shift-IR on low, Exit1-IR on high.
// - Shift-IR shifts instruction toward output; holds on low, Exit1-IR on high.
// - Exit1-IR, Pause-IR and Exit2-IR move as in the data column.
// - Update-IR makes shifted instruction current; then Idle or Select-DR.
// - Extest links chain, drives pins from update values, captures pins.
// - Sample/preload captures and shifts chain while pins stay with system logic.
// - Idcode selects identification register; bypass selects one-bit bypass.
// - Identification register is 32 bits, shifted out low bit first.
// - Chain takes data in at top bit and gives data out from bit zero.
`timescale 1ns/1ps
`default_nettype none
module jtap_tap (
  // System clock and reset
  input  wire logic                        clock,
  input  wire logic                        rstn,
  // Test access pins
  input  wire logic                        test_clock,
  input  wire logic                        test_mode_select,
  input  wire logic                        test_data_in,
  input  wire logic                        testResetN,
  output logic                             test_data_out,
  output logic                             testDataOutEnN,
  // Pin side of the boundary scan chain
  input  wire logic [jtap_pkg::BSC_LEN-1:0] pinCapture,
  output logic      [jtap_pkg::BSC_LEN-1:0] pinUpdate,
  output logic                             pinTestDrive,
  // Status
  output var jtap_pkg::jtap_state_e        tapState,
  output logic      [jtap_pkg::IR_LEN-1:0]  instruction
);

  // ---------------------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------------------
  logic [3:0]                    pinsSync;
  logic [jtap_pkg::BSC_LEN-1:0]  captureSync;
  logic                          tckSync;
  logic                          tmsSync;
  logic                          tdiSync;
  logic                          trstSyncN;

  jtap_sync #(
    .W (4)
  ) u_pin_sync (
    .clock   (clock),
    .rstn    (rstn),
    .asyncIn ({test_clock, test_mode_select, test_data_in, testResetN}),
    .syncOut (pinsSync)
  );

  // Pins that feed the chain are synchronised too; they only matter at capture
  jtap_sync #(
    .W (jtap_pkg::BSC_LEN)
  ) u_capture_sync (
    .clock   (clock),
    .rstn    (rstn),
    .asyncIn (pinCapture),
    .syncOut (captureSync)
  );

  assign tckSync   = pinsSync[3];
  assign tmsSync   = pinsSync[2];
  assign tdiSync   = pinsSync[1];
  assign trstSyncN = pinsSync[0];

  // ---------------------------------------------------------------------------
  // Test clock edge detection
  // ---------------------------------------------------------------------------
  logic tckPrev_q;
  logic tckRise;
  logic tckFall;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tckPrev_q <= 1'b0;
    end else begin
      tckPrev_q <= tckSync;
    end
  end

  // Mode select and data in are taken only on the rising test clock edge
  assign tckRise = tckSync & ~tckPrev_q;
  assign tckFall = ~tckSync & tckPrev_q;

  // ---------------------------------------------------------------------------
  // Controller state machine
  // ---------------------------------------------------------------------------
  jtap_pkg::jtap_state_e state_q;
  jtap_pkg::jtap_state_e state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      jtap_pkg::TEST_LOGIC_RESET: begin
        if (tmsSync) begin
          state_d = jtap_pkg::TEST_LOGIC_RESET;
        end else begin
          state_d = jtap_pkg::RUN_TEST_IDLE;
        end
      end
      jtap_pkg::RUN_TEST_IDLE: begin
        if (tmsSync) begin
          state_d = jtap_pkg::SELECT_DR_SCAN;
        end else begin
          state_d = jtap_pkg::RUN_TEST_IDLE;
        end
      end
      jtap_pkg::SELECT_DR_SCAN: begin
        if (tmsSync) begin
          state_d = jtap_pkg::SELECT_IR_SCAN;
        end else begin
          state_d = jtap_pkg::CAPTURE_DR;
        end
      end
      jtap_pkg::SELECT_IR_SCAN: begin
        // High here closes the five-high path back to reset
        if (tmsSync) begin
          state_d = jtap_pkg::TEST_LOGIC_RESET;
        end else begin
          state_d = jtap_pkg::CAPTURE_IR;
        end
      end
      jtap_pkg::CAPTURE_DR: begin
        if (tmsSync) begin
          state_d = jtap_pkg::EXIT1_DR;
        end else begin
          state_d = jtap_pkg::SHIFT_DR;
        end
      end
      jtap_pkg::SHIFT_DR: begin
        if (tmsSync) begin
          state_d = jtap_pkg::EXIT1_DR;
        end else begin
          state_d = jtap_pkg::SHIFT_DR;
        end
      end
      jtap_pkg::EXIT1_DR: begin
        if (tmsSync) begin
          state_d = jtap_pkg::UPDATE_DR;
        end else begin
          state_d = jtap_pkg::PAUSE_DR;
        end
      end
      jtap_pkg::PAUSE_DR: begin
        if (tmsSync) begin
          state_d = jtap_pkg::EXIT2_DR;
        end else begin
          state_d = jtap_pkg::PAUSE_DR;
        end
      end
      jtap_pkg::EXIT2_DR: begin
        if (tmsSync) begin
          state_d = jtap_pkg::UPDATE_DR;
        end else begin
          state_d = jtap_pkg::SHIFT_DR;
        end
      end
      jtap_pkg::UPDATE_DR: begin
        if (tmsSync) begin
          state_d = jtap_pkg::SELECT_DR_SCAN;
        end else begin
          state_d = jtap_pkg::RUN_TEST_IDLE;
        end
      end
      jtap_pkg::CAPTURE_IR: begin
        if (tmsSync) begin
          state_d = jtap_pkg::EXIT1_IR;
        end else begin
          state_d = jtap_pkg::SHIFT_IR;
        end
      end
      jtap_pkg::SHIFT_IR: begin
        if (tmsSync) begin
          state_d = jtap_pkg::EXIT1_IR;
        end else begin
          state_d = jtap_pkg::SHIFT_IR;
        end
      end
      jtap_pkg::EXIT1_IR: begin
        if (tmsSync) begin
          state_d = jtap_pkg::UPDATE_IR;
        end else begin
          state_d = jtap_pkg::PAUSE_IR;
        end
      end
      jtap_pkg::PAUSE_IR: begin
        if (tmsSync) begin
          state_d = jtap_pkg::EXIT2_IR;
        end else begin
          state_d = jtap_pkg::PAUSE_IR;
        end
      end
      jtap_pkg::EXIT2_IR: begin
        if (tmsSync) begin
          state_d = jtap_pkg::UPDATE_IR;
        end else begin
          state_d = jtap_pkg::SHIFT_IR;
        end
      end
      jtap_pkg::UPDATE_IR: begin
        if (tmsSync) begin
          state_d = jtap_pkg::SELECT_DR_SCAN;
        end else begin
          state_d = jtap_pkg::RUN_TEST_IDLE;
        end
      end
      default: begin
        state_d = jtap_pkg::TEST_LOGIC_RESET;
      end
    endcase
  end

  // Test reset is sampled by the system clock, so it acts with no test clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= jtap_pkg::TEST_LOGIC_RESET;
    end else if (!trstSyncN) begin
      state_q <= jtap_pkg::TEST_LOGIC_RESET;
    end else if (tckRise) begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Instruction register
  // ---------------------------------------------------------------------------
  logic [jtap_pkg::IR_LEN-1:0] irShift_q;
  logic [jtap_pkg::IR_LEN-1:0] ir_q;
  logic                        inReset;

  assign inReset = (state_q == jtap_pkg::TEST_LOGIC_RESET);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irShift_q <= jtap_pkg::IR_CAPTURE_VAL;
    end else if (tckRise && state_q == jtap_pkg::CAPTURE_IR) begin
      irShift_q <= jtap_pkg::IR_CAPTURE_VAL;
    end else if (tckRise && state_q == jtap_pkg::SHIFT_IR) begin
      irShift_q <= {tdiSync, irShift_q[jtap_pkg::IR_LEN-1:1]};
    end
  end

  // Pause and exit states fall through and hold both stages
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ir_q <= jtap_pkg::IR_RESET_VAL;
    end else if (inReset) begin
      ir_q <= jtap_pkg::IR_RESET_VAL;
    end else if (tckRise && state_q == jtap_pkg::UPDATE_IR) begin
      ir_q <= irShift_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Instruction decode
  // ---------------------------------------------------------------------------
  logic selChain;
  logic selId;
  logic selExtest;

  // Anything not decoded falls to bypass
  always_comb begin
    selChain  = 1'b0;
    selId     = 1'b0;
    selExtest = 1'b0;
    if (ir_q == jtap_pkg::OPC_EXTEST) begin
      selChain  = 1'b1;
      selExtest = 1'b1;
    end else if (ir_q == jtap_pkg::OPC_SAMPLE) begin
      selChain  = 1'b1;
    end else if (ir_q == jtap_pkg::OPC_IDCODE) begin
      selId     = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Data registers
  // ---------------------------------------------------------------------------
  logic                          dataCapture;
  logic                          dataShift;
  logic                          dataUpdate;
  logic                          bypass_q;
  logic [jtap_pkg::ID_LEN-1:0]   idShift_q;
  logic [jtap_pkg::BSC_LEN-1:0]  bscShift_q;
  logic [jtap_pkg::BSC_LEN-1:0]  bscUpdate_q;

  assign dataCapture = tckRise && state_q == jtap_pkg::CAPTURE_DR;
  assign dataShift   = tckRise && state_q == jtap_pkg::SHIFT_DR;
  assign dataUpdate  = tckRise && state_q == jtap_pkg::UPDATE_DR;

  // Bypass is the default for every opcode not otherwise decoded
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bypass_q <= 1'b0;
    end else if (dataCapture && !selChain && !selId) begin
      bypass_q <= 1'b0;
    end else if (dataShift && !selChain && !selId) begin
      bypass_q <= tdiSync;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      idShift_q <= jtap_pkg::ID_CODE;
    end else if (dataCapture && selId) begin
      idShift_q <= jtap_pkg::ID_CODE;
    end else if (dataShift && selId) begin
      idShift_q <= {tdiSync, idShift_q[jtap_pkg::ID_LEN-1:1]};
    end
  end

  // Capture happens for both chain opcodes; pins stay with system logic
  // under sample, so capturing is harmless there
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bscShift_q <= jtap_pkg::BSC_RESET_VAL;
    end else if (inReset) begin
      bscShift_q[jtap_pkg::BSC_LEN-1 -: jtap_pkg::BSC_OFF] <= '0;
    end else if (dataCapture && selChain) begin
      bscShift_q <= captureSync;
    end else if (dataShift && selChain) begin
      bscShift_q <= {tdiSync, bscShift_q[jtap_pkg::BSC_LEN-1:1]};
    end
  end

  // Update stage also takes preload values so that extest starts clean
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bscUpdate_q <= jtap_pkg::BSC_RESET_VAL;
    end else if (inReset) begin
      bscUpdate_q[jtap_pkg::BSC_LEN-1 -: jtap_pkg::BSC_OFF] <= '0;
    end else if (dataUpdate && selChain) begin
      bscUpdate_q <= bscShift_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Serial output, changed on the falling test clock edge
  // ---------------------------------------------------------------------------
  logic serialBit;
  logic shifting;

  always_comb begin
    serialBit = bypass_q;
    if (state_q == jtap_pkg::SHIFT_IR) begin
      serialBit = irShift_q[0];
    end else if (selChain) begin
      serialBit = bscShift_q[0];
    end else if (selId) begin
      serialBit = idShift_q[0];
    end
  end

  assign shifting = (state_q == jtap_pkg::SHIFT_DR) || (state_q == jtap_pkg::SHIFT_IR);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      test_data_out  <= 1'b0;
      testDataOutEnN <= 1'b1;
    end else if (tckFall) begin
      test_data_out  <= serialBit;
      testDataOutEnN <= ~shifting;
    end
  end

  // ---------------------------------------------------------------------------
  // Registered status and pin side outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pinUpdate    <= jtap_pkg::BSC_RESET_VAL;
      pinTestDrive <= 1'b0;
      tapState     <= jtap_pkg::TEST_LOGIC_RESET;
      instruction  <= jtap_pkg::IR_RESET_VAL;
    end else begin
      pinUpdate    <= bscUpdate_q;
      pinTestDrive <= selExtest;
      tapState     <= state_q;
      instruction  <= ir_q;
    end
  end

endmodule
`default_nettype wire

//--- dv/jtap_tap_checker.sv
`timescale 1ns/1ps
`default_nettype none
module jtap_tap_checker (
  // Clock and reset
  input wire logic                         clock,
  input wire logic                         rstn,
  // Test access pins
  input wire logic                         test_clock,
  input wire logic                         test_mode_select,
  input wire logic                         test_data_in,
  input wire logic                         testResetN,
  input wire logic                         test_data_out,
  input wire logic                         testDataOutEnN,
  // Chain pins and status
  input wire logic [jtap_pkg::BSC_LEN-1:0] pinCapture,
  input wire logic [jtap_pkg::BSC_LEN-1:0] pinUpdate,
  input wire logic                         pinTestDrive,
  input wire jtap_pkg::jtap_state_e        tapState,
  input wire logic [jtap_pkg::IR_LEN-1:0]  instruction
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // --------
  // Assertions
  // --------
  a_trst_forces_reset: assert property (
    (!testResetN)[*6] |-> tapState == jtap_pkg::TEST_LOGIC_RESET)
    else $error("test reset did not force reset state");
  a_reset_loads_idcode: assert property (
    tapState == jtap_pkg::TEST_LOGIC_RESET |=> instruction == jtap_pkg::IR_RESET_VAL)
    else $error("reset state without default instruction");
  a_reset_clears_top: assert property (
    tapState == jtap_pkg::TEST_LOGIC_RESET |-> ##2 pinUpdate[86:84] == 3'h0)
    else $error("top chain bits not cleared in reset state");
  a_tdo_on_fall: assert property (
    $changed(test_data_out) || $changed(testDataOutEnN)
      |-> !test_clock && $past(test_clock, 6))
    else $error("data out moved away from a test clock fall");
  a_state_on_rise: assert property (
    $changed(tapState) && tapState != jtap_pkg::TEST_LOGIC_RESET
      |-> test_clock && !$past(test_clock, 7))
    else $error("state moved away from a test clock rise");
  a_drive_only_shift: assert property (
    !testDataOutEnN |-> tapState inside {jtap_pkg::SHIFT_DR, jtap_pkg::EXIT1_DR,
      jtap_pkg::SHIFT_IR, jtap_pkg::EXIT1_IR, jtap_pkg::TEST_LOGIC_RESET})
    else $error("data out driven outside a shift");
  a_update_holds: assert property (
    tapState inside {jtap_pkg::CAPTURE_DR, jtap_pkg::SHIFT_DR, jtap_pkg::PAUSE_DR,
      jtap_pkg::EXIT2_DR} |-> $stable(pinUpdate))
    else $error("update stage moved during a data scan");
  a_instr_holds: assert property (
    tapState inside {jtap_pkg::CAPTURE_IR, jtap_pkg::SHIFT_IR, jtap_pkg::PAUSE_IR,
      jtap_pkg::EXIT2_IR} |-> $stable(instruction))
    else $error("instruction moved during an instruction scan");
  a_extest_drives: assert property (
    (instruction == jtap_pkg::OPC_EXTEST)[*2] |-> pinTestDrive)
    else $error("pins not driven under external test");
  a_sample_leaves_pins: assert property (
    (instruction != jtap_pkg::OPC_EXTEST)[*2] |-> !pinTestDrive)
    else $error("pins taken from system logic");

  c_pause_dr: cover property (tapState == jtap_pkg::PAUSE_DR);
  c_pause_ir: cover property (tapState == jtap_pkg::PAUSE_IR);
  c_extest: cover property (pinTestDrive);
endmodule

bind jtap_tap jtap_tap_checker chk_u (
  .clock(clock), .rstn(rstn), .test_clock(test_clock),
  .test_mode_select(test_mode_select), .test_data_in(test_data_in),
  .testResetN(testResetN), .test_data_out(test_data_out),
  .testDataOutEnN(testDataOutEnN), .pinCapture(pinCapture),
  .pinUpdate(pinUpdate), .pinTestDrive(pinTestDrive),
  .tapState(tapState), .instruction(instruction));
`default_nettype wire

//--- dv/jtap_master.sv
`timescale 1ns/1ps
`default_nettype none
module jtap_master (
  // System clock
  input  wire logic clock,
  // Test access pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdoEnN
);
  // Released data out is pulled up
  wire tdoPin = tdoEnN ? 1'b1 : tdo;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // Clock stands low between ticks; mode and data settle while it is low
  task automatic tick(input logic m, input logic d, output logic q);
    @(negedge clock);
    tms = m;
    tdi = d;
    repeat (8) @(negedge clock);
    q = tdoPin;
    tck = 1'b1;
    repeat (15) @(negedge clock);
    tck = 1'b0;
    repeat (7) @(negedge clock);
  endtask

  // Outside shifts the data line toggles, so no stale bit looks valid
  task automatic walk(input logic [7:0] pat, input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      tick(pat[i], ~tdi, q);
    end
  endtask

  // Shifts n bits low bit first, ends in Exit1; may detour through Pause
  task automatic scan(input int n, input int pauseAt,
                      input logic [86:0] din, output logic [86:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1 || i == pauseAt, din[i], dout[i]);
      if (i == pauseAt && i != n - 1) begin
        walk(8'h04, 4);
      end
    end
  endtask
endmodule
`default_nettype wire

//--- dv/jtap_tap_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module jtap_tap_tb_top;
  localparam int L = jtap_pkg::BSC_LEN;
  localparam logic [L-1:0] PAT = {3{29'h1234_5678}};
  logic                  clock;
  logic                  rstn;
  logic                  testResetN;
  logic                  tck;
  logic                  tms;
  logic                  tdi;
  logic                  tdo;
  logic                  tdoEnN;
  logic                  pinTestDrive;
  logic [L-1:0]          pinCapture;
  logic [L-1:0]          pinUpdate;
  logic [L-1:0]          got;
  logic [7:0]            instruction;
  jtap_pkg::jtap_state_e tapState;
  int                    failures;
  int                    comparisons;

  jtap_tap dut_u (
    .clock(clock), .rstn(rstn), .test_clock(tck), .test_mode_select(tms),
    .test_data_in(tdi), .testResetN(testResetN), .test_data_out(tdo),
    .testDataOutEnN(tdoEnN), .pinCapture(pinCapture), .pinUpdate(pinUpdate),
    .pinTestDrive(pinTestDrive), .tapState(tapState), .instruction(instruction));
  jtap_master master_u (
    .clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEnN(tdoEnN));

  always #2 clock = ~clock;

  // --------
  // Helpers
  // --------
  task automatic check(input logic [L-1:0] g, input logic [L-1:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic load_ir(input logic [7:0] opc, input int pauseAt);
    master_u.walk(8'h03, 4);
    master_u.scan(8, pauseAt, L'(opc), got);
    check(L'(got[7:0]), L'(jtap_pkg::IR_CAPTURE_VAL));
    master_u.walk(8'h01, 2);
    check(L'(instruction), L'(opc));
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_reset_id();
    check(L'(instruction), L'(jtap_pkg::IR_RESET_VAL));
    master_u.walk(8'h00, 3);
    check(L'(tapState), L'(jtap_pkg::RUN_TEST_IDLE));
    master_u.walk(8'h01, 3);
    master_u.scan(32, -1, '1, got);
    check(L'(got[31:0]), L'(jtap_pkg::ID_CODE));
    master_u.walk(8'h01, 2);
  endtask

  task automatic t_bypass();
    logic [7:0] opc [2];
    opc = '{jtap_pkg::OPC_BYPASS, 8'h5a};
    for (int i = 0; i < 2; i++) begin
      load_ir(opc[i], i == 0 ? 3 : -1);
      master_u.walk(8'h01, 3);
      master_u.scan(8, -1, L'(8'ha5), got);
      check(L'(got[7:0]), L'(8'h4a));
      master_u.walk(8'h01, 2);
    end
  endtask

  // Preload under sample first, so the pins never see stale chain data
  task automatic t_chain();
    load_ir(jtap_pkg::OPC_SAMPLE, -1);
    master_u.walk(8'h01, 3);
    master_u.scan(L, -1, ~PAT, got);
    check(got, PAT);
    check(L'(pinTestDrive), L'(1'b0));
    master_u.walk(8'h01, 2);
    check(pinUpdate, ~PAT);
    load_ir(jtap_pkg::OPC_EXTEST, -1);
    check(L'(pinTestDrive), L'(1'b1));
    check(pinUpdate, ~PAT);
    pinCapture = ~PAT;
    master_u.walk(8'h01, 3);
    master_u.scan(L, 40, PAT, got);
    check(got, ~PAT);
    master_u.walk(8'h01, 2);
    check(pinUpdate, PAT);
  endtask

  // Start from an instruction capture so no data update disturbs the preload
  task automatic t_five_ones();
    master_u.walk(8'h03, 3);
    master_u.walk(8'h1f, 5);
    check(L'(tapState), L'(jtap_pkg::TEST_LOGIC_RESET));
    check(L'(instruction), L'(jtap_pkg::IR_RESET_VAL));
    check(pinUpdate, {3'h0, PAT[L-4:0]});
    check(L'(pinTestDrive), L'(1'b0));
  endtask

  task automatic t_trst();
    master_u.walk(8'h06, 5);
    check(L'(tapState), L'(jtap_pkg::SHIFT_IR));
    testResetN = 1'b0;
    repeat (8) @(negedge clock);
    check(L'(tapState), L'(jtap_pkg::TEST_LOGIC_RESET));
    testResetN = 1'b1;
    repeat (4) @(negedge clock);
  endtask

  // --------
  // Main sequence and watchdog
  // --------
  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    testResetN = 1'b1;
    pinCapture = PAT;
    failures = 0;
    comparisons = 0;
    repeat (12) @(negedge clock);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    t_reset_id();
    t_bypass();
    t_chain();
    t_five_ones();
    t_trst();
    wrap_up();
  end

  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
